//--- logic/trig_a_pkg.sv
// package for the combinational trigger a selection stage
// assumes one 25 mhz clock, synchronous active-low reset and an axi4-lite register port
package trig_a_pkg;

	// *********************************************
	// bus geometry
	// *********************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int GEN_COUNT = 4;

	// *********************************************
	// register offsets (byte addresses)
	// *********************************************
	localparam logic [7:0] SELECT_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;

	// *********************************************
	// select register fields and reset
	// *********************************************
	localparam int SELECT_WIDTH = 16;
	localparam int GEN1_EN_POS = 0;
	localparam int GEN2_EN_POS = 1;
	localparam int GEN3_EN_POS = 2;
	localparam int GEN4_EN_POS = 3;
	localparam logic [3:0] SELECT_RESET = 4'h0;

	// *********************************************
	// status register fields
	// *********************************************
	localparam int STATUS_SRC_POS = 0;
	localparam int STATUS_TRIG_POS = 4;

	// *********************************************
	// bus answers
	// *********************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// register index returned by the address decoder
	typedef enum logic [1:0] {
		REG_NONE = 2'h0,
		REG_SELECT = 2'h1,
		REG_STATUS = 2'h2
	} reg_sel_t;

	// write and read channel states, one-hot
	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_RESP = 2'b10
	} rd_state_t;

endpackage : trig_a_pkg

//--- logic/trig_a_select_reg.sv
// four enable bits of the trigger a select register
// assumes the bus slave gives a one-cycle write pulse with lane 0 strobe
`timescale 1ns/1ps

module trig_a_select_reg
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_pulse,
	input wire logic lane0_strb,
	input wire logic [7:0] wr_byte,
	output logic [3:0] en_q
);

	logic [3:0] en_d;

	// only the low nibble exists; bits 15..4 are not stored at all
	always_comb
	begin
		en_d = en_q;
		if (wr_pulse && lane0_strb)
		begin
			en_d = wr_byte[3:0];
		end
	end

	// enables clear at reset
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			en_q <= trig_a_pkg::SELECT_RESET;
		end
		else
		begin
			en_q <= en_d;
		end
	end

endmodule : trig_a_select_reg

//--- logic/trig_a_merge.sv
// gates each generator trigger with its enable and ors them into trigger a
// assumes generator triggers are synchronous to clk
`timescale 1ns/1ps

module trig_a_merge
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] gen_trig,
	input wire logic [3:0] en,
	output logic [3:0] src_q,
	output logic trig_a_q
);

	logic [3:0] src_d;
	logic trig_a_d;

	// one gate per generator; bit n serves generator n+1
	genvar g;
	generate
		for (g = 0; g < trig_a_pkg::GEN_COUNT; g++)
		begin : gate_gen
			assign src_d[g] = gen_trig[g] & en[g];
		end
	endgenerate

	// the or of enabled sources; nothing enabled leaves trigger a low
	always_comb
	begin
		trig_a_d = |src_d;
	end

	// registered so the output is glitch free, at the cost of one cycle
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			src_q <= 4'h0;
			trig_a_q <= 1'b0;
		end
		else
		begin
			src_q <= src_d;
			trig_a_q <= trig_a_d;
		end
	end

endmodule : trig_a_merge

//--- logic/combo_trigger_a_enable.sv
// top of the combinational trigger a stage with its axi4-lite register port
// assumes the four generator triggers and the bus are all on clk
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps

// Contract
// - select bit 3 set lets generator 4 trigger into trigger a, clear blocks it
// - select bit 2 set lets generator 3 trigger into trigger a, clear blocks it
// - select bit 1 set lets generator 2 trigger into trigger a, clear blocks it
// - select bit 0 set lets generator 1 trigger into trigger a, clear blocks it
// - trigger a is the or of enabled triggers, low when none enabled
module combo_trigger_a_enable
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] gen_trig,
	output logic trig_a,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// *********************************************
	// address decode
	// *********************************************

	// word decode shared by the write and read paths; low address bits ignored
	function automatic trig_a_pkg::reg_sel_t decode_addr(input logic [7:0] addr);
		trig_a_pkg::reg_sel_t sel;
		sel = trig_a_pkg::REG_NONE;
		if ({addr[7:2], 2'b00} == trig_a_pkg::SELECT_OFFSET)
		begin
			sel = trig_a_pkg::REG_SELECT;
		end
		else if ({addr[7:2], 2'b00} == trig_a_pkg::STATUS_OFFSET)
		begin
			sel = trig_a_pkg::REG_STATUS;
		end
		return sel;
	endfunction : decode_addr

	// *********************************************
	// datapath instances
	// *********************************************

	logic [3:0] en_q;
	logic [3:0] src_q;
	logic trig_a_q;
	logic sel_wr_pulse;
	// held write payload, declared here because the select register reads it
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	trig_a_select_reg u_select
	(
		.clk(clk),
		.rst_n(rst_n),
		.wr_pulse(sel_wr_pulse),
		.lane0_strb(wstrb_q[0]),
		.wr_byte(wdata_q[7:0]),
		.en_q(en_q)
	);

	trig_a_merge u_merge
	(
		.clk(clk),
		.rst_n(rst_n),
		.gen_trig(gen_trig),
		.en(en_q),
		.src_q(src_q),
		.trig_a_q(trig_a_q)
	);

	// trigger a leaves straight from the merge flop
	assign trig_a = trig_a_q;

	// *********************************************
	// write channel
	// *********************************************

	trig_a_pkg::wr_state_t wr_state_q;
	trig_a_pkg::wr_state_t wr_state_d;
	logic aw_have_q;
	logic aw_have_d;
	logic w_have_q;
	logic w_have_d;
	logic [7:0] awaddr_q;
	logic [7:0] awaddr_d;
	logic [31:0] wdata_d;
	logic [3:0] wstrb_d;
	logic awready_q;
	logic awready_d;
	logic wready_q;
	logic wready_d;
	logic bvalid_q;
	logic bvalid_d;
	logic [1:0] bresp_q;
	logic [1:0] bresp_d;
	logic wr_go;
	trig_a_pkg::reg_sel_t wr_sel;

	// address and data are caught independently, the write commits once both are held
	always_comb
	begin
		wr_state_d = wr_state_q;
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		wr_sel = decode_addr(awaddr_q);
		wr_go = 1'b0;
		sel_wr_pulse = 1'b0;
		case (wr_state_q)
			trig_a_pkg::WR_IDLE:
			begin
				if (s_axi_awvalid && awready_q)
				begin
					aw_have_d = 1'b1;
					awaddr_d = s_axi_awaddr;
				end
				if (s_axi_wvalid && wready_q)
				begin
					w_have_d = 1'b1;
					wdata_d = s_axi_wdata;
					wstrb_d = s_axi_wstrb;
				end
				if (aw_have_q && w_have_q)
				begin
					wr_go = 1'b1;
					aw_have_d = 1'b0;
					w_have_d = 1'b0;
					bvalid_d = 1'b1;
					wr_state_d = trig_a_pkg::WR_RESP;
					// status is read-only: a write there is accepted and dropped
					bresp_d = (wr_sel == trig_a_pkg::REG_NONE) ?
						trig_a_pkg::RESP_SLVERR : trig_a_pkg::RESP_OKAY;
					sel_wr_pulse = (wr_sel == trig_a_pkg::REG_SELECT);
				end
			end
			trig_a_pkg::WR_RESP:
			begin
				if (s_axi_bready)
				begin
					bvalid_d = 1'b0;
					wr_state_d = trig_a_pkg::WR_IDLE;
				end
			end
			default:
			begin
				wr_state_d = trig_a_pkg::WR_IDLE;
				bvalid_d = 1'b0;
			end
		endcase
		// ready only while idle and the holding slot is empty
		awready_d = (wr_state_d == trig_a_pkg::WR_IDLE) && !aw_have_d && !wr_go;
		wready_d = (wr_state_d == trig_a_pkg::WR_IDLE) && !w_have_d && !wr_go;
	end

	// write channel registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_state_q <= trig_a_pkg::WR_IDLE;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= trig_a_pkg::RESP_OKAY;
		end
		else
		begin
			wr_state_q <= wr_state_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// *********************************************
	// read channel
	// *********************************************

	trig_a_pkg::rd_state_t rd_state_q;
	trig_a_pkg::rd_state_t rd_state_d;
	logic arready_q;
	logic arready_d;
	logic rvalid_q;
	logic rvalid_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0] rresp_q;
	logic [1:0] rresp_d;
	trig_a_pkg::reg_sel_t rd_sel;

	// read data is captured at the address handshake and held until taken
	always_comb
	begin
		rd_state_d = rd_state_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		rd_sel = decode_addr(s_axi_araddr);
		case (rd_state_q)
			trig_a_pkg::RD_IDLE:
			begin
				if (s_axi_arvalid && arready_q)
				begin
					rvalid_d = 1'b1;
					rd_state_d = trig_a_pkg::RD_RESP;
					rdata_d = 32'h0000_0000;
					rresp_d = trig_a_pkg::RESP_OKAY;
					case (rd_sel)
						trig_a_pkg::REG_SELECT:
						begin
							// upper select bits are not stored and read zero
							rdata_d[3:0] = en_q;
						end
						trig_a_pkg::REG_STATUS:
						begin
							rdata_d[trig_a_pkg::STATUS_SRC_POS +: 4] = src_q;
							rdata_d[trig_a_pkg::STATUS_TRIG_POS] = trig_a_q;
						end
						default:
						begin
							rresp_d = trig_a_pkg::RESP_SLVERR;
						end
					endcase
				end
			end
			trig_a_pkg::RD_RESP:
			begin
				if (s_axi_rready)
				begin
					rvalid_d = 1'b0;
					rd_state_d = trig_a_pkg::RD_IDLE;
				end
			end
			default:
			begin
				rd_state_d = trig_a_pkg::RD_IDLE;
				rvalid_d = 1'b0;
			end
		endcase
		// one read in flight: no new address until the data is taken
		arready_d = (rd_state_d == trig_a_pkg::RD_IDLE);
	end

	// read channel registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rd_state_q <= trig_a_pkg::RD_IDLE;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= trig_a_pkg::RESP_OKAY;
		end
		else
		begin
			rd_state_q <= rd_state_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

endmodule : combo_trigger_a_enable

//--- verif/gen_trig_src.sv
// behavioural source of the four generator trigger outputs
// assumes the bench seeds the random generator before use
`timescale 1ns/1ps

module gen_trig_src
(
	input wire logic clk,
	input wire logic rand_on,
	input wire logic [3:0] fixed,
	output logic [3:0] gen_trig
);
	// triggers move just after each edge, like a real generator flop
	always @(posedge clk)
	begin
		if (rand_on)
			gen_trig <= 4'($urandom);
		else
			gen_trig <= fixed;
	end
endmodule : gen_trig_src

//--- verif/trig_a_chk.sv
// timing checks on the trigger a stage, seen from its ports
// assumes it is bound into the top module
`timescale 1ns/1ps

module trig_a_chk
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] gen_trig,
	input wire logic trig_a,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid
);
	logic [3:0] en_s, wd_s;
	logic aw_s, w_s, sel_s, ws_s, rsel_s;

	// shadow enables: written once both halves of a write are taken
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			en_s <= 4'h0;
			aw_s <= 1'b0;
			w_s <= 1'b0;
		end
		else if (aw_s && w_s)
		begin
			if (sel_s && ws_s)
				en_s <= wd_s;
			aw_s <= 1'b0;
			w_s <= 1'b0;
		end
		else
		begin
			aw_s <= aw_s | (s_axi_awvalid & s_axi_awready);
			w_s <= w_s | (s_axi_wvalid & s_axi_wready);
		end
	end

	// payload captures; no reset needed, only read when flagged
	always_ff @(posedge clk)
	begin
		if (s_axi_awvalid && s_axi_awready)
			sel_s <= (s_axi_awaddr[7:2] == 6'h00);
		if (s_axi_wvalid && s_axi_wready)
		begin
			wd_s <= s_axi_wdata[3:0];
			ws_s <= s_axi_wstrb[0];
		end
		if (s_axi_arvalid && s_axi_arready)
			rsel_s <= (s_axi_araddr[7:2] == 6'h00);
	end

	AST_GEN4: assert property (@(posedge clk) disable iff (!rst_n)
		(gen_trig == 4'h8) |=> (trig_a == $past(en_s[3]))) else $error("gen4 gating wrong");
	AST_GEN3: assert property (@(posedge clk) disable iff (!rst_n)
		(gen_trig == 4'h4) |=> (trig_a == $past(en_s[2]))) else $error("gen3 gating wrong");
	AST_GEN2: assert property (@(posedge clk) disable iff (!rst_n)
		(gen_trig[1] && !en_s[1] && (gen_trig & en_s) == 4'h0) |=> !trig_a)
		else $error("gen2 leaks");
	AST_GEN1: assert property (@(posedge clk) disable iff (!rst_n)
		(gen_trig[0] && en_s[0]) |=> trig_a) else $error("gen1 lost");
	AST_OR: assert property (@(posedge clk) disable iff (!rst_n)
		trig_a == $past(|(gen_trig & en_s))) else $error("trigger a not the or");
	AST_NONE: assert property (@(posedge clk) disable iff (!rst_n)
		(en_s == 4'h0)[*2] |-> !trig_a) else $error("trigger a high with none enabled");
	AST_RDSEL: assert property (@(posedge clk) disable iff (!rst_n)
		(s_axi_rvalid && rsel_s) |-> (s_axi_rdata == {28'h0, en_s}))
		else $error("select readback wrong");
	AST_RST: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> (!trig_a && !s_axi_bvalid && !s_axi_rvalid))
		else $error("reset state wrong");
endmodule : trig_a_chk

bind combo_trigger_a_enable trig_a_chk chk (.clk(clk), .rst_n(rst_n), .gen_trig(gen_trig),
	.trig_a(trig_a), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid));

//--- verif/testbench.sv
// self-checking bench for the trigger a stage
// assumes the trigger source model and the checker are compiled alongside
`timescale 1ns/1ps

module testbench;
	logic clk, rst_n, rand_on, trig_a, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [3:0] fixed, gen_trig, wstrb, g_prev;
	logic [7:0] awaddr, araddr;
	logic [2:0] prot;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	int bad_count, n_tests, en_m;

	gen_trig_src src (.clk(clk), .rand_on(rand_on), .fixed(fixed), .gen_trig(gen_trig));

	combo_trigger_a_enable uut (.clk(clk), .rst_n(rst_n), .gen_trig(gen_trig),
		.trig_a(trig_a), .s_axi_awaddr(awaddr), .s_axi_awprot(prot),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(prot), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	// reference: or of the triggers whose enable is set
	function automatic logic ref_or(input logic [3:0] g, input int en);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 4; i++)
			if (g[i] && en[i])
				r = 1'b1;
		return r;
	endfunction : ref_or

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	// a spent wait is a mismatch and ends the run
	task automatic guard(input int k);
		if (k >= 50)
		begin
			bad_count++;
			close_out();
		end
	endtask : guard

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		int k;
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// each channel is released at the edge its own ready is seen high
		for (k = 0; k < 50 && !(aw_done && w_done); k++)
		begin
			@(posedge clk);
			if (awready && !aw_done)
			begin
				awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (wready && !w_done)
			begin
				wvalid <= 1'b0;
				w_done = 1'b1;
			end
		end
		guard(k);
		for (k = 0; k < 50; k++)
		begin
			@(posedge clk);
			if (bvalid)
				break;
		end
		bready <= 1'b0;
		guard(k);
		check(bresp, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int k;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		rready <= 1'b0;
		guard(k);
		check(rdata, d);
		check(rresp, r);
	endtask : rd

	// 25 mhz clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// main sequence: reset, every enable against every pattern, refusals, random run
	initial
	begin
		{rst_n, rand_on, fixed, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb, prot} = '0;
		bad_count = 0;
		n_tests = 0;
		void'($urandom(32'hd35d));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(trig_a_pkg::SELECT_OFFSET, 32'h0, trig_a_pkg::RESP_OKAY);
		for (int e = 0; e < 16; e++)
		begin
			wr(trig_a_pkg::SELECT_OFFSET, {28'($urandom), 4'(e)}, 4'hf, trig_a_pkg::RESP_OKAY);
			en_m = e;
			rd(trig_a_pkg::SELECT_OFFSET, 32'(e), trig_a_pkg::RESP_OKAY);
			for (int p = 0; p < 16; p++)
			begin
				fixed <= 4'(p);
				repeat (3) @(posedge clk);
				check(trig_a, ref_or(4'(p), en_m));
			end
		end
		// lane 0 not strobed: the write is dropped
		wr(trig_a_pkg::SELECT_OFFSET, 32'hffff_fff0, 4'he, trig_a_pkg::RESP_OKAY);
		rd(trig_a_pkg::SELECT_OFFSET, 32'h0000_000f, trig_a_pkg::RESP_OKAY);
		wr(8'h40, 32'h0, 4'hf, trig_a_pkg::RESP_SLVERR);
		rd(8'h40, 32'h0, trig_a_pkg::RESP_SLVERR);
		wr(trig_a_pkg::SELECT_OFFSET, 32'h0000_0005, 4'h1, trig_a_pkg::RESP_OKAY);
		en_m = 5;
		// status is read-only: a write is answered but leaves the enables alone
		wr(trig_a_pkg::STATUS_OFFSET, 32'h0000_000a, 4'hf, trig_a_pkg::RESP_OKAY);
		rd(trig_a_pkg::SELECT_OFFSET, 32'h0000_0005, trig_a_pkg::RESP_OKAY);
		// all four triggers high with enables 0101: sources 0101 and trigger a set
		rd(trig_a_pkg::STATUS_OFFSET, 32'h0000_0015, trig_a_pkg::RESP_OKAY);
		rand_on <= 1'b1;
		@(posedge clk);
		g_prev = gen_trig;
		repeat (40)
		begin
			@(posedge clk);
			check(trig_a, ref_or(g_prev, en_m));
			g_prev = gen_trig;
		end
		// reset in mid-run clears the enables
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		check(trig_a, 1'b0);
		rd(trig_a_pkg::SELECT_OFFSET, 32'h0, trig_a_pkg::RESP_OKAY);
		close_out();
	end
endmodule : testbench
